//--- hdl/atr_readout_cfg.svh
`ifndef ATR_READOUT_CFG_SVH
`define ATR_READOUT_CFG_SVH

// Register addresses on the serial register port.
`define ATR_ADDR_PIN_B_ROUTE 7'h0e
`define ATR_ADDR_RATE_CFG 7'h10
`define ATR_ADDR_CTRL_C3 7'h12
`define ATR_ADDR_CTRL_C4 7'h13
`define ATR_ADDR_SELFTEST 7'h14
`define ATR_ADDR_CTRL_C6 7'h15
`define ATR_ADDR_CTRL_C7 7'h16
`define ATR_ADDR_CTRL_C8 7'h17
`define ATR_ADDR_CTRL_C10 7'h19
`define ATR_ADDR_STATUS 7'h1e
`define ATR_ADDR_TEMP_L 7'h20
`define ATR_ADDR_TEMP_H 7'h21
`define ATR_ADDR_X_L 7'h28
`define ATR_ADDR_X_H 7'h29
`define ATR_ADDR_Y_L 7'h2a
`define ATR_ADDR_Y_H 7'h2b
`define ATR_ADDR_Z_L 7'h2c
`define ATR_ADDR_Z_H 7'h2d

// Reset value of every writable register.
`define ATR_REG_RESET 8'h00

// Field positions.
`define ATR_ACC_EN_MSB 7
`define ATR_ACC_EN_LSB 5
`define ATR_HOLD_BIT 6
`define ATR_SEL_MSB 1
`define ATR_SEL_LSB 0
`define ATR_XDA_BIT 0
`define ATR_TDA_BIT 2
`define ATR_ROUTE_TEMP_BIT 1

// Temperature format: 256 LSB per degree, zero at 25 degrees.
`define ATR_TEMP_LSB_PER_C 256
`define ATR_TEMP_ZERO_C 25
`define ATR_TEMP_OFFSET (`ATR_TEMP_LSB_PER_C * `ATR_TEMP_ZERO_C)

// Electrostatic test force expressed in output LSB.
`define ATR_TEST_FORCE 17'h00800

// Timing: a 20 MHz clock and a 104 Hz temperature rate.
`define ATR_CLK_HZ 20000000
`define ATR_TEMP_RATE_HZ 104
`define ATR_TEMP_PERIOD_CYC (`ATR_CLK_HZ / `ATR_TEMP_RATE_HZ)

`endif

//--- hdl/atr_pkg.sv
package atr_pkg;
	typedef enum logic [1:0] {
		ATR_TEST_OFF = 2'b00,
		ATR_TEST_POS = 2'b01,
		ATR_TEST_NEG = 2'b10,
		ATR_TEST_RSVD = 2'b11
	} atr_test_sel_t;
	typedef enum logic [0:0] {
		ATR_PH_ADDR = 1'b0,
		ATR_PH_DATA = 1'b1
	} atr_phase_t;
	typedef logic signed [15:0] atr_sample_t;
endpackage : atr_pkg

//--- hdl/atr_reg_if.sv
`timescale 1ns/10ps
interface atr_reg_if;
	logic [6:0] addr;
	logic wr;
	logic [7:0] wdata;
	logic rd;
	logic [7:0] rdata;
	logic busy;
	modport eng (output addr, output wr, output wdata, output rd, output busy, input rdata);
	modport regs (input addr, input wr, input wdata, input rd, input busy, output rdata);
endinterface : atr_reg_if

//--- hdl/atr_spi_engine.sv
`timescale 1ns/10ps
module atr_spi_engine (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic spc,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	atr_reg_if.eng bus
);
	import atr_pkg::*;

	// -------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------
	logic cs_m, cs_s, spc_m, spc_s, spc_p, sdi_m, sdi_s;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{cs_m, cs_s} <= 2'h3;
			{spc_m, spc_s, spc_p} <= 3'h7;
			{sdi_m, sdi_s} <= 2'h0;
		end else begin
			{cs_m, cs_s} <= {cs_n, cs_m};
			{spc_m, spc_s, spc_p} <= {spc, spc_m, spc_s};
			{sdi_m, sdi_s} <= {sdi, sdi_m};
		end
	end

	// -------------------------------------------------
	// Frame engine
	// -------------------------------------------------
	atr_phase_t phase_q, phase_d;
	logic rw_q, rw_d, wr_q, wr_d, rd_q, rd_d, sdo_q, sdo_d, oe_q, oe_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, wdata_q, wdata_d;
	logic [6:0] addr_q, addr_d;

	always_comb begin
		phase_d = phase_q;
		rw_d = rw_q;
		bit_d = bit_q;
		sh_d = sh_q;
		tx_d = tx_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		sdo_d = sdo_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		oe_d = 1'b0;
		if (wr_q) begin
			addr_d = addr_q + 7'h01;
		end
		if (cs_s) begin
			phase_d = ATR_PH_ADDR;
			bit_d = 3'h0;
		end else begin
			oe_d = (phase_q == ATR_PH_DATA) && rw_q;
			if (spc_s && !spc_p) begin
				sh_d = {sh_q[6:0], sdi_s};
				bit_d = bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					if (phase_q == ATR_PH_ADDR) begin
						rw_d = sh_q[6];
						addr_d = {sh_q[5:0], sdi_s};
						rd_d = sh_q[6];
						phase_d = ATR_PH_DATA;
					end else if (rw_q) begin
						// Reads run on to the next address so a burst covers a whole sample.
						addr_d = addr_q + 7'h01;
						rd_d = 1'b1;
					end else begin
						wr_d = 1'b1;
						wdata_d = {sh_q[6:0], sdi_s};
					end
				end
			end
			if (!spc_s && spc_p) begin
				sdo_d = tx_q[7];
				tx_d = {tx_q[6:0], 1'b0};
			end
		end
		if (rd_q) begin
			tx_d = bus.rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_q <= ATR_PH_ADDR;
			rw_q <= 1'b0;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			addr_q <= 7'h00;
			wdata_q <= 8'h00;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			rw_q <= rw_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = oe_q;
	assign bus.addr = addr_q;
	assign bus.wr = wr_q;
	assign bus.wdata = wdata_q;
	assign bus.rd = rd_q;
	assign bus.busy = !cs_s;
endmodule : atr_spi_engine

//--- hdl/atr_readout.sv
`timescale 1ns/10ps
`include "atr_readout_cfg.svh"
module atr_readout #(
	parameter int unsigned TEMP_PERIOD_CYC = `ATR_TEMP_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic spc,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire atr_pkg::atr_sample_t acc_x_in,
	input wire atr_pkg::atr_sample_t acc_y_in,
	input wire atr_pkg::atr_sample_t acc_z_in,
	input wire logic acc_sample_valid,
	input wire atr_pkg::atr_sample_t temp_in,
	output logic accel_on,
	output logic temp_sensor_on,
	output atr_pkg::atr_test_sel_t selftest_select,
	output logic interrupt_pin_b
);
	import atr_pkg::*;

	atr_reg_if bus ();

	atr_spi_engine u_engine (
		.clk(clk),
		.nrst(nrst),
		.cs_n(cs_n),
		.spc(spc),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.bus(bus)
	);

	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	function automatic atr_sample_t atr_sat(input logic signed [16:0] v);
		atr_sample_t r;
		r = v[15:0];
		if (v > 17'sh07fff) begin
			r = 16'sh7fff;
		end else if (v < -17'sh08000) begin
			r = -16'sh8000;
		end
		return r;
	endfunction : atr_sat

	function automatic atr_sample_t atr_apply_force(input atr_sample_t raw, input atr_test_sel_t sel);
		logic signed [16:0] sum;
		sum = {raw[15], raw};
		if (sel == ATR_TEST_POS) begin
			sum = sum + $signed(`ATR_TEST_FORCE);
		end else if (sel == ATR_TEST_NEG) begin
			sum = sum - $signed(`ATR_TEST_FORCE);
		end
		return atr_sat(sum);
	endfunction : atr_apply_force

	// -------------------------------------------------
	// Control registers
	// -------------------------------------------------
	logic [7:0] rate_cfg_q, rate_cfg_d, c3_q, c3_d, c4_q, c4_d, test_q, test_d;
	logic [7:0] c6_q, c6_d, c7_q, c7_d, c8_q, c8_d, c10_q, c10_d, route_q, route_d;

	always_comb begin
		rate_cfg_d = rate_cfg_q;
		c3_d = c3_q;
		c4_d = c4_q;
		test_d = test_q;
		c6_d = c6_q;
		c7_d = c7_q;
		c8_d = c8_q;
		c10_d = c10_q;
		route_d = route_q;
		if (bus.wr) begin
			case (bus.addr)
				`ATR_ADDR_RATE_CFG: rate_cfg_d = bus.wdata;
				`ATR_ADDR_CTRL_C3: c3_d = bus.wdata;
				`ATR_ADDR_CTRL_C4: c4_d = bus.wdata;
				`ATR_ADDR_SELFTEST: test_d = bus.wdata;
				`ATR_ADDR_CTRL_C6: c6_d = bus.wdata;
				`ATR_ADDR_CTRL_C7: c7_d = bus.wdata;
				`ATR_ADDR_CTRL_C8: c8_d = bus.wdata;
				`ATR_ADDR_CTRL_C10: c10_d = bus.wdata;
				`ATR_ADDR_PIN_B_ROUTE: route_d = bus.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rate_cfg_q <= `ATR_REG_RESET;
			c3_q <= `ATR_REG_RESET;
			c4_q <= `ATR_REG_RESET;
			test_q <= `ATR_REG_RESET;
			c6_q <= `ATR_REG_RESET;
			c7_q <= `ATR_REG_RESET;
			c8_q <= `ATR_REG_RESET;
			c10_q <= `ATR_REG_RESET;
			route_q <= `ATR_REG_RESET;
		end else begin
			rate_cfg_q <= rate_cfg_d;
			c3_q <= c3_d;
			c4_q <= c4_d;
			test_q <= test_d;
			c6_q <= c6_d;
			c7_q <= c7_d;
			c8_q <= c8_d;
			c10_q <= c10_d;
			route_q <= route_d;
		end
	end

	// -------------------------------------------------
	// Sample capture and flags
	// -------------------------------------------------
	// A frame that is being clocked holds the output bytes when the hold bit
	// is set, so high and low halves always come from the same sample.
	logic frozen, acc_en, temp_tick, acc_read, temp_read;
	atr_test_sel_t sel;
	atr_sample_t ax_s_q, ax_s_d, ay_s_q, ay_s_d, az_s_q, az_s_d, t_s_q, t_s_d;
	atr_sample_t ax_q, ax_d, ay_q, ay_d, az_q, az_d, t_q, t_d;
	logic acc_new_q, acc_new_d, t_new_q, t_new_d, xda_q, xda_d, tda_q, tda_d;
	logic acc_on_q, acc_on_d, pin_b_q, pin_b_d;
	logic [17:0] t_cnt_q, t_cnt_d;
	atr_test_sel_t sel_q, sel_d;

	// hold bit freezes outputs during a frame
	assign frozen = c3_q[`ATR_HOLD_BIT] && bus.busy;
	assign acc_en = (rate_cfg_q[`ATR_ACC_EN_MSB:`ATR_ACC_EN_LSB] != 3'h0);
	assign sel = atr_test_sel_t'(test_q[`ATR_SEL_MSB:`ATR_SEL_LSB]);
	assign temp_tick = acc_on_q && (t_cnt_q == 18'(TEMP_PERIOD_CYC - 1));
	assign acc_read = bus.rd && (bus.addr >= `ATR_ADDR_X_L) && (bus.addr <= `ATR_ADDR_Z_H);
	assign temp_read = bus.rd && ((bus.addr == `ATR_ADDR_TEMP_L) || (bus.addr == `ATR_ADDR_TEMP_H));

	always_comb begin
		ax_s_d = ax_s_q;
		ay_s_d = ay_s_q;
		az_s_d = az_s_q;
		t_s_d = t_s_q;
		ax_d = ax_q;
		ay_d = ay_q;
		az_d = az_q;
		t_d = t_q;
		acc_new_d = acc_new_q;
		t_new_d = t_new_q;
		xda_d = xda_q;
		tda_d = tda_q;
		acc_on_d = acc_en;
		sel_d = sel;
		t_cnt_d = t_cnt_q + 18'h00001;
		if (!acc_on_q) begin
			t_cnt_d = 18'h00000;
		end
		if (temp_tick) begin
			t_cnt_d = 18'h00000;
			// remove the 25 degree zero level
			t_s_d = atr_sat({temp_in[15], temp_in} - 17'(`ATR_TEMP_OFFSET));
			t_new_d = 1'b1;
		end
		// output is acceleration plus the test force for POS, minus it for NEG, saturated
		if (acc_sample_valid && acc_on_q) begin
			ax_s_d = atr_apply_force(acc_x_in, sel_q);
			ay_s_d = atr_apply_force(acc_y_in, sel_q);
			az_s_d = atr_apply_force(acc_z_in, sel_q);
			acc_new_d = 1'b1;
		end
		if (acc_read) begin
			xda_d = 1'b0;
		end
		if (temp_read) begin
			tda_d = 1'b0;
		end
		// new sample sets flag, winning over a read
		if (acc_new_q && !frozen) begin
			ax_d = ax_s_q;
			ay_d = ay_s_q;
			az_d = az_s_q;
			acc_new_d = acc_sample_valid && acc_on_q;
			xda_d = 1'b1;
		end
		if (t_new_q && !frozen) begin
			t_d = t_s_q;
			t_new_d = temp_tick;
			tda_d = 1'b1;
		end
		// temperature ready routed to pin b
		pin_b_d = route_q[`ATR_ROUTE_TEMP_BIT] && tda_d;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ax_s_q <= 16'sh0000;
			ay_s_q <= 16'sh0000;
			az_s_q <= 16'sh0000;
			t_s_q <= 16'sh0000;
			ax_q <= 16'sh0000;
			ay_q <= 16'sh0000;
			az_q <= 16'sh0000;
			t_q <= 16'sh0000;
			acc_new_q <= 1'b0;
			t_new_q <= 1'b0;
			xda_q <= 1'b0;
			tda_q <= 1'b0;
			acc_on_q <= 1'b0;
			sel_q <= ATR_TEST_OFF;
			pin_b_q <= 1'b0;
			t_cnt_q <= 18'h00000;
		end else begin
			ax_s_q <= ax_s_d;
			ay_s_q <= ay_s_d;
			az_s_q <= az_s_d;
			t_s_q <= t_s_d;
			ax_q <= ax_d;
			ay_q <= ay_d;
			az_q <= az_d;
			t_q <= t_d;
			acc_new_q <= acc_new_d;
			t_new_q <= t_new_d;
			xda_q <= xda_d;
			tda_q <= tda_d;
			acc_on_q <= acc_on_d;
			sel_q <= sel_d;
			pin_b_q <= pin_b_d;
			t_cnt_q <= t_cnt_d;
		end
	end

	assign accel_on = acc_on_q;
	assign temp_sensor_on = acc_on_q;
	assign selftest_select = sel_q;
	assign interrupt_pin_b = pin_b_q;

	// -------------------------------------------------
	// Read multiplexer
	// -------------------------------------------------
	logic [7:0] rmux;
	always_comb begin
		rmux = 8'h00;
		unique case (bus.addr)
			`ATR_ADDR_PIN_B_ROUTE: rmux = route_q;
			`ATR_ADDR_RATE_CFG: rmux = rate_cfg_q;
			`ATR_ADDR_CTRL_C3: rmux = c3_q;
			`ATR_ADDR_CTRL_C4: rmux = c4_q;
			`ATR_ADDR_SELFTEST: rmux = test_q;
			`ATR_ADDR_CTRL_C6: rmux = c6_q;
			`ATR_ADDR_CTRL_C7: rmux = c7_q;
			`ATR_ADDR_CTRL_C8: rmux = c8_q;
			`ATR_ADDR_CTRL_C10: rmux = c10_q;
			`ATR_ADDR_STATUS: begin
				rmux[`ATR_XDA_BIT] = xda_q;
				rmux[`ATR_TDA_BIT] = tda_q;
			end
			`ATR_ADDR_TEMP_L: rmux = t_q[7:0];
			`ATR_ADDR_TEMP_H: rmux = t_q[15:8];
			`ATR_ADDR_X_L: rmux = ax_q[7:0];
			`ATR_ADDR_X_H: rmux = ax_q[15:8];
			`ATR_ADDR_Y_L: rmux = ay_q[7:0];
			`ATR_ADDR_Y_H: rmux = ay_q[15:8];
			`ATR_ADDR_Z_L: rmux = az_q[7:0];
			`ATR_ADDR_Z_H: rmux = az_q[15:8];
			default: rmux = 8'h00;
		endcase
	end
	assign bus.rdata = rmux;

	// -------------------------------------------------
	// Assertions
	// -------------------------------------------------
	logic [17:0] gap_q;
	logic seen_q;
	always_ff @(posedge clk) begin
		if (!nrst || !acc_on_q || temp_tick) begin
			gap_q <= 18'h00000;
			seen_q <= acc_on_q && temp_tick;
		end else begin
			gap_q <= gap_q + 18'h00001;
		end
	end

	temp_power_a : assert property (@(posedge clk) disable iff (!nrst)
		!acc_en |=> !temp_sensor_on && !temp_tick)
		else $error("temperature channel on while acceleration is off");
	temp_rate_a : assert property (@(posedge clk) disable iff (!nrst)
		temp_tick && seen_q |-> gap_q == 18'(TEMP_PERIOD_CYC - 1))
		else $error("temperature tick spacing wrong");
	temp_flag_a : assert property (@(posedge clk) disable iff (!nrst)
		t_new_q && !frozen |=> tda_q && t_q == $past(t_s_q))
		else $error("temperature flag not set on new result");
	pin_route_a : assert property (@(posedge clk) disable iff (!nrst)
		##1 interrupt_pin_b == ($past(route_q[`ATR_ROUTE_TEMP_BIT]) && tda_q))
		else $error("pin b does not follow routed temperature flag");
	temp_zero_a : assert property (@(posedge clk) disable iff (!nrst)
		temp_tick && temp_in == 16'sh1900 |=> t_s_q == 16'sh0000)
		else $error("25 degrees does not read zero");
	test_force_a : assert property (@(posedge clk) disable iff (!nrst)
		acc_sample_valid && acc_on_q && sel_q == ATR_TEST_OFF |=> ax_s_q == $past(acc_x_in))
		else $error("output shifted with self-test off");
	accel_flag_a : assert property (@(posedge clk) disable iff (!nrst)
		acc_new_q && !frozen |=> xda_q && ax_q == $past(ax_s_q))
		else $error("acceleration flag not set on new sample");
	accel_clear_a : assert property (@(posedge clk) disable iff (!nrst)
		acc_read && !(acc_new_q && !frozen) |=> !xda_q)
		else $error("acceleration flag not cleared by read");
	axis_map_a : assert property (@(posedge clk) disable iff (!nrst)
		bus.addr == `ATR_ADDR_Y_H |-> bus.rdata == ay_q[15:8])
		else $error("Y high byte misplaced");
	temp_high_a : assert property (@(posedge clk) disable iff (!nrst)
		bus.addr == `ATR_ADDR_TEMP_H |-> bus.rdata == t_q[15:8])
		else $error("temperature high byte misplaced");
endmodule : atr_readout

//--- verif/atr_host_model.sv
`timescale 1ns/10ps
module atr_host_model #(
	parameter int HALF = 6
) (
	input wire logic clk,
	output logic cs_n,
	output logic spc,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic [7:0] dat [0:5];
	logic last = 1'b0;
	initial begin
		cs_n = 1'b1;
		spc = 1'b1;
		sdi = 1'b0;
	end
	// A released data line reads as the inverse of its last level, so a silent device never passes by luck.
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			repeat (HALF) @(posedge clk);
			#1 spc = 1'b0;
			sdi = tx[i];
			repeat (HALF) @(posedge clk);
			#1 rx[i] = sdo_oe ? sdo : ~last;
			last = rx[i];
			spc = 1'b1;
		end
	endtask : shift
	task automatic frame(input logic rd, input logic [6:0] a, input int n);
		logic [7:0] rx;
		@(posedge clk);
		#1 cs_n = 1'b0;
		shift({rd, a}, rx);
		for (int k = 0; k < n; k++) begin
			shift(dat[k], rx);
			if (rd) begin
				dat[k] = rx;
			end
		end
		repeat (HALF) @(posedge clk);
		#1 cs_n = 1'b1;
		sdi = ~sdi;
		repeat (HALF) @(posedge clk);
	endtask : frame
endmodule : atr_host_model

//--- verif/tb.sv
`timescale 1ns/10ps
`include "atr_readout_cfg.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module tb;
	import atr_pkg::*;
	// The temperature period is long enough that a three-byte read always ends before the next tick.
	localparam int TP = 1000;
	localparam int SETTLE = 200;
	localparam int F = `ATR_TEST_FORCE;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic av = 1'b0;
	logic cs_n, spc, sdi, sdo, sdo_oe, acc_on, temp_on, pin_b;
	atr_sample_t ax = '0, ay = '0, az = '0, tin = '0;
	atr_test_sel_t sel;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int sum [3];
	int plain [3];
	int base [3];
	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	atr_readout #(.TEMP_PERIOD_CYC(TP)) dut_u (.clk(clk), .nrst(nrst), .cs_n(cs_n), .spc(spc), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .acc_x_in(ax), .acc_y_in(ay), .acc_z_in(az), .acc_sample_valid(av),
		.temp_in(tin), .accel_on(acc_on), .temp_sensor_on(temp_on), .selftest_select(sel),
		.interrupt_pin_b(pin_b));
	atr_host_model host_u (.clk(clk), .cs_n(cs_n), .spc(spc), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
	// ----------------------------------------
	// Expectations and transfers
	// ----------------------------------------
	function automatic logic [15:0] sat16(input int v);
		if (v > 32767) begin
			return 16'h7fff;
		end
		if (v < -32768) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction : sat16
	function automatic int force_of(input atr_test_sel_t m);
		return (m == ATR_TEST_POS) ? F : (m == ATR_TEST_NEG) ? -F : 0;
	endfunction : force_of
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_u.dat[0] = d;
		host_u.frame(1'b0, a, 1);
	endtask : wr
	task automatic rd1(input logic [6:0] a, output logic [7:0] d);
		host_u.frame(1'b1, a, 1);
		d = host_u.dat[0];
	endtask : rd1
	task automatic wait_pin(output int t);
		t = -1;
		for (int n = 0; n < 2 * TP && t < 0; n++) begin
			@(posedge clk);
			#1 if (pin_b === 1'b1) t = cyc;
		end
		`CHK("pin rise", 1'b1, pin_b)
	endtask : wait_pin
	task automatic sample(input atr_test_sel_t m, input int rx, input int ry, input int rz);
		logic [7:0] st;
		logic [15:0] e;
		int r [3];
		r = '{rx, ry, rz};
		foreach (r[i]) r[i] += int'($urandom_range(14)) - 7;
		@(posedge clk);
		#1 ax = r[0][15:0];
		ay = r[1][15:0];
		az = r[2][15:0];
		av = 1'b1;
		@(posedge clk);
		#1 av = 1'b0;
		repeat (4) @(posedge clk);
		rd1(7'h1e, st);
		`CHK("accel flag", 1'b1, st[`ATR_XDA_BIT])
		host_u.frame(1'b1, 7'h28, 6);
		foreach (r[i]) begin
			e = sat16(r[i] + force_of(m));
			`CHK("axis", e, {host_u.dat[2 * i + 1], host_u.dat[2 * i]})
			sum[i] += int'($signed({host_u.dat[2 * i + 1], host_u.dat[2 * i]}));
		end
		rd1(7'h1e, st);
		`CHK("accel flag clear", 1'b0, st[`ATR_XDA_BIT])
	endtask : sample
	task automatic done(input string n);
		$display("test %s done", n);
	endtask : done
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [7:0] b;
		logic [15:0] v;
		int t2, t3, d, af;
		static atr_test_sel_t modes [4] = '{ATR_TEST_OFF, ATR_TEST_POS, ATR_TEST_NEG, ATR_TEST_RSVD};
		static logic [6:0] regs [10] = '{7'h0e, 7'h10, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h19, 7'h7f};
		logic [15:0] temps [5];
		void'($urandom(7511));
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		foreach (regs[i]) begin
			rd1(regs[i], b);
			`CHK("reset reg", 8'h00, b)
		end
		`CHK("accel on", 1'b0, acc_on)
		`CHK("temp on", 1'b0, temp_on)
		done("reset_values");
		wr(7'h10, 8'ha8);
		wr(7'h12, 8'h44);
		foreach (regs[i]) if (regs[i] > 7'h12 && regs[i] < 7'h1a) wr(regs[i], 8'h00);
		rd1(7'h10, b);
		`CHK("rate cfg", 8'ha8, b)
		`CHK("accel on", 1'b1, acc_on)
		`CHK("temp on", 1'b1, temp_on)
		repeat (SETTLE) @(posedge clk);
		done("prepare");
		foreach (base[i]) base[i] = int'($urandom_range(16000)) - 8000;
		foreach (modes[m]) begin
			wr(7'h14, {6'h00, modes[m]});
			`CHK("select", modes[m], sel)
			repeat (SETTLE) @(posedge clk);
			sample(modes[m], base[0], base[1], base[2]);
			sum = '{0, 0, 0};
			repeat (5) sample(modes[m], base[0], base[1], base[2]);
			af = force_of(modes[m]);
			af = af < 0 ? -af : af;
			for (int i = 0; i < 3; i++) begin
				if (m == 0) plain[i] = sum[i] / 5;
				d = sum[i] / 5 - plain[i];
				d = d < 0 ? -d : d;
				`CHK("verdict", 1'b1, (d + 16 >= af) && (d <= af + 16))
			end
		end
		wr(7'h14, 8'h01);
		sample(ATR_TEST_POS, 32'sh00007f00, -32'sh00007ff8, 0);
		done("selftest");
		wr(7'h14, 8'h00);
		wr(7'h0e, 8'h00);
		repeat (TP + 10) @(posedge clk);
		rd1(7'h1e, b);
		`CHK("temp flag", 1'b1, b[`ATR_TDA_BIT])
		`CHK("pin unrouted", 1'b0, pin_b)
		wr(7'h0e, 8'h02);
		`CHK("pin routed", 1'b1, pin_b)
		temps = '{16'h0000, 16'h1900, 16'h3200, 16'h8000, 16'($urandom)};
		foreach (temps[i]) begin
			#1 tin = temps[i];
			host_u.frame(1'b1, 7'h20, 2);
			wait_pin(t2);
			host_u.frame(1'b1, 7'h20, 2);
			v = sat16(int'($signed(temps[i])) - `ATR_TEMP_OFFSET);
			`CHK("temp", v, {host_u.dat[1], host_u.dat[0]})
			`CHK("pin cleared", 1'b0, pin_b)
			rd1(7'h21, b);
			`CHK("temp high", v[15:8], b)
		end
		wait_pin(t2);
		host_u.frame(1'b1, 7'h20, 2);
		wait_pin(t3);
		`CHK("temp period", TP, t3 - t2)
		done("temperature");
		wr(7'h14, 8'h00);
		wr(7'h10, 8'h00);
		host_u.frame(1'b1, 7'h20, 2);
		`CHK("accel off", 1'b0, acc_on)
		`CHK("temp off", 1'b0, temp_on)
		`CHK("select off", ATR_TEST_OFF, sel)
		d = 0;
		repeat (2 * TP) begin
			@(posedge clk);
			#1 if (pin_b !== 1'b0) d++;
		end
		`CHK("temp idle", 0, d)
		done("power_down");
		tally_and_finish();
	end
endmodule : tb
